// ==== core/tmrin_map.vh ====
// Register map and field positions of the timer input logic block.
// Assumes a word-aligned AHB-Lite slave decoding haddr[4:2].
`ifndef TMRIN_MAP_VH
`define TMRIN_MAP_VH

// Byte offsets of the registers
`define TMRIN_CTRL_OFS 5'h00
`define TMRIN_STAT_OFS 5'h04
`define TMRIN_MASK_OFS 5'h08
`define TMRIN_CNT0_OFS 5'h0C
`define TMRIN_CNT1_OFS 5'h10
`define TMRIN_PINS_OFS 5'h14

// Control register fields
`define TMRIN_CTRL_RUN0 0
`define TMRIN_CTRL_RUN1 1
`define TMRIN_CTRL_TMR0_GATE_SEL 2
`define TMRIN_CTRL_TMR1_GATE_SEL 3
`define TMRIN_CTRL_CNTM0 4
`define TMRIN_CTRL_CNTM1 5
`define TMRIN_CTRL_EDGE0 6
`define TMRIN_CTRL_EDGE1 7
`define TMRIN_CTRL_W 8
`define TMRIN_CTRL_RST 8'h00

// Status and mask fields
`define TMRIN_ST_IRQ0 0
`define TMRIN_ST_IRQ1 1
`define TMRIN_ST_CNT0 2
`define TMRIN_ST_CNT1 3
`define TMRIN_ST_W 4
`define TMRIN_ST_RST 4'h0

`endif

// ==== core/tmrin_sync_edge.v ====
// Two-stage synchroniser with falling-edge detection for one pin.
// Assumes the pin is asynchronous to mclk_i; idles high after reset.
`timescale 1ns/1ps
`default_nettype none

module tmrin_sync_edge (
  input wire mclk_i,
  input wire arst_n_i,
  input wire pin_i,
  output wire level_o,
  output wire fall_o
);

  reg meta_q;
  reg sync_q;
  reg prev_q;

  // Meta stage read only by sync stage; prev keeps last sampled level
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      prev_q <= 1'b1;
    end else begin
      meta_q <= pin_i;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level_o = sync_q;
  // Sampled high then sampled low
  assign fall_o = prev_q & ~sync_q;

endmodule

`default_nettype wire

// ==== core/tmrin_top.v ====
// Input side of two 16-bit timers: gate control, event counting,
// external interrupt flags, with an AHB-Lite register slave.
// Assumes one clock mclk_i (10 MHz) and pins asynchronous to it.
//
// Chosen here: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "tmrin_map.vh"

module tmrin_top (
  input wire mclk_i,
  input wire arst_n_i,
  input wire ext_irq0_n_i,
  input wire ext_irq1_n_i,
  input wire tmr0_count_in_i,
  input wire tmr1_count_in_i,
  input wire irq_ack0_i,
  input wire irq_ack1_i,
  input wire hsel_i,
  input wire [31:0] haddr_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire [2:0] hsize_i,
  input wire [31:0] hwdata_i,
  input wire hready_i,
  output wire [31:0] hrdata_o,
  output wire hreadyout_o,
  output wire hresp_o,
  output wire tmr0_run_o,
  output wire tmr1_run_o,
  output wire irq_o
);

  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  ////////////////////////////////////////////////////////////////////

  wire [3:0] pin_raw;
  wire [3:0] pin_lvl;
  wire [3:0] pin_fall;

  // Bit order matches the pin image register: irq0, irq1, count 0, count 1
  assign pin_raw[0] = ext_irq0_n_i;
  assign pin_raw[1] = ext_irq1_n_i;
  assign pin_raw[2] = tmr0_count_in_i;
  assign pin_raw[3] = tmr1_count_in_i;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
      tmrin_sync_edge u_sync (
        .mclk_i(mclk_i),
        .arst_n_i(arst_n_i),
        .pin_i(pin_raw[gi]),
        .level_o(pin_lvl[gi]),
        .fall_o(pin_fall[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // AHB-Lite slave
  ////////////////////////////////////////////////////////////////////

  reg [`TMRIN_CTRL_W-1:0] ctrl_q;
  reg [`TMRIN_ST_W-1:0] stat_q;
  reg [`TMRIN_ST_W-1:0] mask_q;
  reg [15:0] cnt0_q;
  reg [15:0] cnt1_q;
  reg wr_pend_q;
  reg [4:0] wr_addr_q;
  reg [31:0] rdata_q;

  wire req;
  wire [4:0] addr_lo;
  wire wr_take;
  wire rd_take;

  assign req = hsel_i & htrans_i[1] & hready_i;
  assign addr_lo = {haddr_i[4:2], 2'b00};

  // Qualified transfers; hsize is ignored, every access is a whole word
  assign wr_take = req & hwrite_i;
  assign rd_take = req & ~hwrite_i;

  // Read mux used at the address phase
  function [31:0] rd_word;
    input [4:0] a;
    begin
      case (a)
        `TMRIN_CTRL_OFS: rd_word = {24'h000000, ctrl_q};
        `TMRIN_STAT_OFS: rd_word = {28'h0000000, stat_q};
        `TMRIN_MASK_OFS: rd_word = {28'h0000000, mask_q};
        `TMRIN_CNT0_OFS: rd_word = {16'h0000, cnt0_q};
        `TMRIN_CNT1_OFS: rd_word = {16'h0000, cnt1_q};
        `TMRIN_PINS_OFS: rd_word = {28'h0000000, pin_lvl};
        default: rd_word = 32'h00000000;
      endcase
    end
  endfunction

  // Write decode, one compare per register; unmapped offsets hit nothing
  function reg_hit;
    input [4:0] a;
    input [4:0] ofs;
    begin
      reg_hit = (a == ofs);
    end
  endfunction

  // Write address phase; the data come a cycle later, so the offset is kept
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 5'h00;
    end else begin
      wr_pend_q <= wr_take;
      if (wr_take) begin
        wr_addr_q <= addr_lo;
      end
    end
  end

  // Read data taken at the address edge; zero wait states, unmapped reads zero
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_q <= 32'h00000000;
    end else if (rd_take) begin
      rdata_q <= rd_word(addr_lo);
    end
  end

  assign hrdata_o = rdata_q;
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;

  wire wr_ctrl;
  wire wr_stat;
  wire wr_mask;
  wire wr_cnt0;
  wire wr_cnt1;

  // Data phase strobes, one per writable register
  assign wr_ctrl = wr_pend_q & reg_hit(wr_addr_q, `TMRIN_CTRL_OFS);
  assign wr_stat = wr_pend_q & reg_hit(wr_addr_q, `TMRIN_STAT_OFS);
  assign wr_mask = wr_pend_q & reg_hit(wr_addr_q, `TMRIN_MASK_OFS);
  assign wr_cnt0 = wr_pend_q & reg_hit(wr_addr_q, `TMRIN_CNT0_OFS);
  assign wr_cnt1 = wr_pend_q & reg_hit(wr_addr_q, `TMRIN_CNT1_OFS);

  // Control register; upper write data bits are dropped
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_q <= `TMRIN_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= hwdata_i[`TMRIN_CTRL_W-1:0];
    end
  end

  // Mask register, same layout as status
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mask_q <= `TMRIN_ST_RST;
    end else if (wr_mask) begin
      mask_q <= hwdata_i[`TMRIN_ST_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Gate control and counters
  ////////////////////////////////////////////////////////////////////

  wire tmr0_gate_sel;
  wire tmr1_gate_sel;
  wire run0;
  wire run1;
  wire inc0;
  wire inc1;
  wire run_en0;
  wire run_en1;
  wire cnt_mode0;
  wire cnt_mode1;

  assign tmr0_gate_sel = ctrl_q[`TMRIN_CTRL_TMR0_GATE_SEL];
  assign tmr1_gate_sel = ctrl_q[`TMRIN_CTRL_TMR1_GATE_SEL];

  // Software run bits and counter-mode bits of the control register
  assign run_en0 = ctrl_q[`TMRIN_CTRL_RUN0];
  assign run_en1 = ctrl_q[`TMRIN_CTRL_RUN1];
  assign cnt_mode0 = ctrl_q[`TMRIN_CTRL_CNTM0];
  assign cnt_mode1 = ctrl_q[`TMRIN_CTRL_CNTM1];

  assign run0 = run_en0 & (~tmr0_gate_sel | pin_lvl[0]);
  assign run1 = run_en1 & (~tmr1_gate_sel | pin_lvl[1]);

  assign tmr0_run_o = run0;
  assign tmr1_run_o = run1;

  assign inc0 = run0 & cnt_mode0 & pin_fall[2];
  assign inc1 = run1 & cnt_mode1 & pin_fall[3];

  // Event counter 0; a software write takes priority over an increment
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt0_q <= 16'h0000;
    end else if (wr_cnt0) begin
      cnt0_q <= hwdata_i[15:0];
    end else if (inc0) begin
      cnt0_q <= cnt0_q + 16'h0001;
    end
  end

  // Event counter 1; same priority, wraps to zero past the top value
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt1_q <= 16'h0000;
    end else if (wr_cnt1) begin
      cnt1_q <= hwdata_i[15:0];
    end else if (inc1) begin
      cnt1_q <= cnt1_q + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Interrupt flags
  ////////////////////////////////////////////////////////////////////

  wire ext_irq0_edge_sel;
  wire ext_irq1_edge_sel;
  wire set0;
  wire set1;
  wire [`TMRIN_ST_W-1:0] set_vec;
  wire [`TMRIN_ST_W-1:0] clr_vec;
  wire ext_irq0_flag;
  wire ext_irq1_flag;
  wire wrap0;
  wire wrap1;
  wire [`TMRIN_ST_W-1:0] sw_clr;
  wire [`TMRIN_ST_W-1:0] hw_clr;
  wire [`TMRIN_ST_W-1:0] stat_d;
  wire irq_ext;
  wire irq_wrap;

  assign ext_irq0_edge_sel = ctrl_q[`TMRIN_CTRL_EDGE0];
  assign ext_irq1_edge_sel = ctrl_q[`TMRIN_CTRL_EDGE1];

  assign set0 = ext_irq0_edge_sel ? pin_fall[0] : ~pin_lvl[0];
  assign set1 = ext_irq1_edge_sel ? pin_fall[1] : ~pin_lvl[1];

  // A wrap is an increment at the top value; a load in that cycle wins
  assign wrap0 = inc0 & ~wr_cnt0 & (cnt0_q == 16'hFFFF);
  assign wrap1 = inc1 & ~wr_cnt1 & (cnt1_q == 16'hFFFF);

  // Counter-overflow events share the status register
  assign set_vec = {wrap1, wrap0, set1, set0};
  // Software clears by writing ones; acknowledges clear only the pin flags
  assign sw_clr = {`TMRIN_ST_W{wr_stat}} & hwdata_i[`TMRIN_ST_W-1:0];
  assign hw_clr = {2'b00, irq_ack1_i, irq_ack0_i};
  assign clr_vec = sw_clr | hw_clr;

  // Set wins: an event in the clear cycle keeps its flag
  assign stat_d = (stat_q & ~clr_vec) | set_vec;

  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      stat_q <= `TMRIN_ST_RST;
    end else begin
      stat_q <= stat_d;
    end
  end

  assign ext_irq0_flag = stat_q[`TMRIN_ST_IRQ0];
  assign ext_irq1_flag = stat_q[`TMRIN_ST_IRQ1];

  // Pin flags each pass their own mask bit
  assign irq_ext = (ext_irq0_flag & mask_q[`TMRIN_ST_IRQ0])
                 | (ext_irq1_flag & mask_q[`TMRIN_ST_IRQ1]);
  // Wrap flags share the line; masked ones must be polled in status
  assign irq_wrap = (stat_q[`TMRIN_ST_CNT0] & mask_q[`TMRIN_ST_CNT0])
                  | (stat_q[`TMRIN_ST_CNT1] & mask_q[`TMRIN_ST_CNT1]);

  // Level interrupt while any unmasked flag is set
  assign irq_o = irq_ext | irq_wrap;

endmodule

`default_nettype wire

// ==== dv/tmrin_pin_src.sv ====
// Board-side sources of the gate, interrupt and count pins.
// Assumes the bench calls its tasks; pins have pull-ups.
`timescale 1ns/1ps
`default_nettype none
module tmrin_pin_src (
  input wire logic mclk_i,
  output logic [3:0] pin_o
);
  // Pull-ups keep every pin high when no source drives it
  initial pin_o = 4'hF;
  // Level change just after an edge, then four edges to let it settle
  task automatic drv(input int b, input logic v);
    @(posedge mclk_i);
    pin_o[b] <= v;
    repeat (4) @(posedge mclk_i);
  endtask
  // Low pulse long enough for two-stage sampling to see it
  task automatic pulse(input int b);
    drv(b, 1'b0);
    drv(b, 1'b1);
  endtask
endmodule
`default_nettype wire

// ==== dv/tmrin_props.sv ====
// Port checker of the timer input block.
// Assumes one clock and pins that idle high through reset.
`timescale 1ns/1ps
`default_nettype none
module tmrin_props (
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic ext_irq0_n_i,
  input wire logic ext_irq1_n_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic tmr0_run_o,
  input wire logic tmr1_run_o,
  input wire logic irq_o
);
  logic [3:0] wa_q;
  logic [1:0] age_q;
  logic [7:0] ctl_q;
  logic [1:0] msk_q;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);
  ////////////////////////////////////////
  // Shadow control and mask; age hides pin history from before reset
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wa_q <= 4'h0;
      age_q <= 2'h0;
      ctl_q <= 8'h00;
      msk_q <= 2'h0;
    end else begin
      wa_q <= {hsel_i && htrans_i[1] && hready_i && hwrite_i, haddr_i[4:2]};
      age_q <= age_q + {1'b0, age_q != 2'h3};
      if (wa_q == 4'h8) ctl_q <= hwdata_i[7:0];
      if (wa_q == 4'hA) msk_q <= hwdata_i[1:0];
    end
  end
  sequence s_rd;
    hsel_i && htrans_i[1] && hready_i && !hwrite_i;
  endsequence
  property p_tmr0_gate_sel;
    age_q[1] |-> tmr0_run_o == (ctl_q[0] && (!ctl_q[2] || $past(ext_irq0_n_i, 2)));
  endproperty
  a_tmr0_gate_sel: assert property (p_tmr0_gate_sel) else $error("run0 wrong");
  property p_tmr1_gate_sel;
    age_q[1] |-> tmr1_run_o == (ctl_q[1] && (!ctl_q[3] || $past(ext_irq1_n_i, 2)));
  endproperty
  a_tmr1_gate_sel: assert property (p_tmr1_gate_sel) else $error("run1 wrong");
  property p_rise0;
    age_q == 2'h3 && $rose(tmr0_run_o) && $stable(ctl_q) |-> !$past(ext_irq0_n_i, 3);
  endproperty
  a_rise0: assert property (p_rise0) else $error("run0 rose early");
  property p_lvl0;
    age_q[1] && !ctl_q[6] && !$past(ext_irq0_n_i, 2) |-> ##[1:2] (irq_o || !msk_q[0]);
  endproperty
  a_lvl0: assert property (p_lvl0) else $error("level 0 no irq");
  property p_lvl1;
    age_q[1] && !ctl_q[7] && !$past(ext_irq1_n_i, 2) |-> ##[1:2] (irq_o || !msk_q[1]);
  endproperty
  a_lvl1: assert property (p_lvl1) else $error("level 1 no irq");
  property p_rdy;
    hreadyout_o && !hresp_o;
  endproperty
  a_rdy: assert property (p_rdy) else $error("wait or error");
  property p_hold;
    !$past(hsel_i && htrans_i[1] && hready_i && !hwrite_i) |-> $stable(hrdata_o);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_unmap;
    s_rd ##0 haddr_i[4:2] > 3'h5 |=> hrdata_o == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
endmodule
bind tmrin_top tmrin_props u_props (.*);
`default_nettype wire

// ==== dv/tmrin_top_tb_top.sv ====
// Bench of the timer input block over AHB-Lite with a pin source.
// Assumes zero-wait bus answers and the bound checker.
`timescale 1ns/1ps
`default_nettype none
`include "tmrin_map.vh"
module tmrin_top_tb_top;
  logic mclk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [1:0] ack = 2'h0;
  logic hsel_i = 1'b0;
  logic hwrite_i = 1'b0;
  logic [1:0] htrans_i = 2'h0;
  logic [4:0] haddr = 5'h00;
  logic [31:0] hwdata_i = 32'h0;
  logic [31:0] rd;
  wire logic [31:0] hrdata_o;
  wire logic [3:0] pin;
  wire logic rdy;
  wire logic [2:0] ri;
  int failures = 0;
  int check_count = 0;
  tmrin_pin_src src (.mclk_i(mclk_i), .pin_o(pin));
  tmrin_top uut (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .ext_irq0_n_i(pin[0]),
    .ext_irq1_n_i(pin[1]), .tmr0_count_in_i(pin[2]), .tmr1_count_in_i(pin[3]),
    .irq_ack0_i(ack[0]), .irq_ack1_i(ack[1]), .hsel_i(hsel_i), .haddr_i({27'h0, haddr}),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i),
    .hready_i(rdy), .hrdata_o(hrdata_o), .hreadyout_o(rdy), .hresp_o(),
    .tmr0_run_o(ri[0]), .tmr1_run_o(ri[1]), .irq_o(ri[2]));
  // Free-running 10 MHz clock
  initial forever #50 mclk_i = ~mclk_i;
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %0t %h %h", $time, seen, exp);
    end
  endtask
  // One single word transfer; waits on the slave's ready in both phases
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    haddr <= a;
    hwrite_i <= w;
    do @(posedge mclk_i); while (rdy !== 1'b1);
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= d;
    do @(posedge mclk_i); while (rdy !== 1'b1);
    rd = hrdata_o;
  endtask
  task automatic rc(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  // Run and irq outputs looked at mid-cycle, away from the edge
  task automatic pc(input logic [2:0] e);
    repeat (3) @(negedge mclk_i);
    chk({29'h0, ri}, {29'h0, e});
  endtask
  task automatic finish_test;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Watchdog: the run needs far fewer than five thousand cycles
  initial begin
    #500000;
    failures++;
    finish_test;
  end
  // Main sequence
  initial begin
    repeat (2) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    rc(`TMRIN_STAT_OFS, 32'h0);
    rc(5'h18, 32'h0);
    rc(`TMRIN_PINS_OFS, 32'hF);
    bus(1'b1, `TMRIN_CTRL_OFS, 32'h0F);
    for (int i = 0; i < 2; i++) begin
      src.drv(i, 1'b0);
      pc(3'(2 - i));
      rc(`TMRIN_PINS_OFS, 32'(15 - (1 << i)));
      src.drv(i, 1'b1);
      pc(3'h3);
    end
    // Counting from the top value of counter 0 wraps it
    bus(1'b1, `TMRIN_CTRL_OFS, 32'h33);
    bus(1'b1, `TMRIN_STAT_OFS, 32'hF);
    bus(1'b1, `TMRIN_CNT0_OFS, 32'hFFFF);
    bus(1'b1, `TMRIN_CNT1_OFS, 32'h5);
    repeat (2) begin
      src.pulse(2);
      src.pulse(3);
    end
    rc(`TMRIN_CNT0_OFS, 32'h1);
    rc(`TMRIN_CNT1_OFS, 32'h7);
    rc(`TMRIN_STAT_OFS, 32'h4);
    // Edge mode: a clear sticks while the pin is still low, a rise sets nothing
    bus(1'b1, `TMRIN_CTRL_OFS, 32'hC0);
    bus(1'b1, `TMRIN_MASK_OFS, 32'h3);
    bus(1'b1, `TMRIN_STAT_OFS, 32'hF);
    for (int i = 0; i < 2; i++) begin
      src.drv(i, 1'b0);
      rc(`TMRIN_STAT_OFS, 32'(1 << i));
      pc(3'h4);
      bus(1'b1, `TMRIN_STAT_OFS, 32'(1 << i));
      pc(3'h0);
      src.drv(i, 1'b1);
    end
    rc(`TMRIN_STAT_OFS, 32'h0);
    // Level mode: a clear cannot stick while the pin stays low
    bus(1'b1, `TMRIN_CTRL_OFS, 32'h00);
    for (int i = 0; i < 2; i++) begin
      src.drv(i, 1'b0);
      bus(1'b1, `TMRIN_STAT_OFS, 32'h3);
      rc(`TMRIN_STAT_OFS, 32'(1 << i));
      bus(1'b1, `TMRIN_MASK_OFS, 32'h0);
      pc(3'h0);
      bus(1'b1, `TMRIN_MASK_OFS, 32'h3);
      src.drv(i, 1'b1);
      ack <= 2'(1 << i);
      @(posedge mclk_i);
      ack <= 2'h0;
      rc(`TMRIN_STAT_OFS, 32'h0);
    end
    finish_test;
  end
endmodule
`default_nettype wire
